/* File: rtl/buck_ctrl_pkg.sv */
// Constants shared by the buck regulator control logic.
// Assumes a single 50 MHz internal clock and strap levels from an on-chip ADC.
//
// Overview of operation
// RULE1: Source frequency strap current, then sense it.
// RULE2: Decode frequency and overcurrent strap into settings.
// RULE3: Source mode strap current, then sense it.
// RULE4: Decode mode strap into mode and timing.
// RULE5: Forced continuous: alternate switches, clock-synchronised.
// RULE6: Diode emulation: low side off at zero-cross. The code turns it off at zero-cross only while in DCM, in either skip mode.
// RULE7: Two pulses without zero-cross: return to continuous.
// RULE8: High efficiency continuous: modulator paces, not clock.
// RULE9: Seven consecutive zero-crosses enter discontinuous conduction.
// RULE10: Discontinuous on-pulse is 25 percent longer.
// RULE11: Soft-start 400 us, power-good delay 300 us.
// RULE12: 4x timing gives 1.6 ms and 1.2 ms.
// RULE13: Reference follows ramp, then fixed 600 mV.
// RULE14: Discontinuous frequency falls with load, modulator paced.
// RULE15: Forced continuous never leaves continuous conduction.
// RULE16: Power-good released only while feedback in window.
// RULE17: Straps latched once per start-up, then held.
// RULE18: Consecutive counters clear on opposite event, state change.
`default_nettype none

package buck_ctrl_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_MHZ = 50;          // Internal clock rate in MHz.
  localparam int SS_1X_US = 400;        // Nominal soft-start time in us.
  localparam int PG_1X_US = 300;        // Nominal power-good delay in us.
  localparam int STRAP_SETTLE_US = 10;  // Time the strap current settles in us.
  localparam int SS_1X_CYCLES = SS_1X_US * CLK_MHZ;
  localparam int PG_1X_CYCLES = PG_1X_US * CLK_MHZ;
  localparam int SETTLE_CYCLES = STRAP_SETTLE_US * CLK_MHZ;
  localparam int TIMING_4X_MULT = 4;    // Scale of the slow timing option.
  localparam int CNT_W = 20;            // Width of the long timing counters.

  // ==========================================================================
  // Reference and conduction control
  // ==========================================================================
  localparam logic [9:0] REF_MV = 10'h258;  // Fixed reference, 600 mV.
  localparam int ZC_ENTER_COUNT = 7;        // Zero-crosses to enter DCM.
  localparam int NZC_EXIT_COUNT = 2;        // Pulses without one to leave.
  localparam int DCM_EXT_SHIFT = 2;         // On-time gains one quarter.

  // ==========================================================================
  // Strap level codes from the sense converter
  // ==========================================================================
  localparam logic [2:0] LVL_GND = 3'h0;    // Pin tied to ground.
  localparam logic [2:0] LVL_R24K3 = 3'h1;  // 24.3 kOhm to ground.
  localparam logic [2:0] LVL_R57K6 = 3'h2;  // 57.6 kOhm to ground.
  localparam logic [2:0] LVL_R105K = 3'h3;  // 105 kOhm to ground.
  localparam logic [2:0] LVL_R174K = 3'h4;  // 174 kOhm to ground.
  // Any higher code means floating or tied to the internal rail.

  // ==========================================================================
  // Setting encodings and reset values
  // ==========================================================================
  localparam logic [1:0] FSW_750K = 2'h0;   // 750 kHz.
  localparam logic [1:0] FSW_1100K = 2'h1;  // 1100 kHz.
  localparam logic [1:0] FSW_2000K = 2'h2;  // 2000 kHz.
  localparam logic [1:0] MODE_FORCED = 2'h0;    // forced_continuous.
  localparam logic [1:0] MODE_HIGH_EFF = 2'h1;  // high_efficiency_skip.
  localparam logic [1:0] MODE_DIODE = 2'h2;     // diode_emulation.
  localparam logic [1:0] FSW_RST = FSW_1100K;
  localparam logic OCP_HIGH_RST = 1'b0;
  localparam logic [1:0] MODE_RST = MODE_FORCED;
  localparam logic TIMING_4X_RST = 1'b0;

endpackage

`default_nettype wire

/* File: rtl/consec_count.sv */
// Saturating counter of consecutive switching-cycle events.
// Assumes one step per switching cycle from the pulse engine.
`default_nettype none

module consec_count #(
  parameter int TARGET = 2
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clear,    // Conduction state changed.
  input wire logic i_step,     // One switching cycle has ended.
  input wire logic i_hit,      // The cycle showed the counted event.
  output logic o_reached       // Count stands at the target.
);

  localparam int W = $clog2(TARGET + 1);

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  if (TARGET < 1) begin : g_bad_target
    $error("consec_count needs a target of at least one");
  end

  logic [W-1:0] cnt_r;  // Consecutive events so far.

  // ==========================================================================
  // Counter
  // ==========================================================================
  // A miss restarts the run; saturation avoids wrapping back below target.
  always_ff @(posedge i_clock) begin
    if (i_rst || i_clear) begin
      cnt_r <= '0;  // see RULE18
    end else if (i_step && !i_hit) begin
      cnt_r <= '0;  // see RULE18
    end else if (i_step && cnt_r != W'(TARGET)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign o_reached = (cnt_r == W'(TARGET));

endmodule

`default_nettype wire

/* File: rtl/buck_mode_softstart_control.sv */
// Start-up sequencing, strap decode and conduction control of a buck regulator.
// Assumes strap levels, zero-cross and window comparators are synchronous.
`default_nettype none

module buck_mode_softstart_control
  import buck_ctrl_pkg::*;
#(
  parameter int SS_CYCLES = SS_1X_CYCLES,  // Soft-start cycles at 1x.
  parameter int PG_CYCLES = PG_1X_CYCLES,  // Power-good delay cycles at 1x.
  parameter int ON_W = 8                   // Width of the on-time request.
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,                  // Converter enable level.
  input wire logic i_restart,                 // Pulse: rerun start-up.
  input wire logic [2:0] i_freq_ocp_strap_lvl,
  input wire logic [2:0] i_mode_strap_pin_lvl,
  input wire logic i_clock_tick,              // Oscillator pulse.
  input wire logic i_mod_trigger,             // Modulator asks for a pulse.
  input wire logic [ON_W-1:0] i_on_time,      // On-time in clock cycles.
  input wire logic i_zero_cross,              // Inductor current hit zero.
  input wire logic i_fb_in_window,            // Feedback within 83..117 %.
  input wire logic i_power_good_out_i,        // Pin level, not needed here.
  output logic o_freq_ocp_strap_src,
  output logic o_mode_strap_pin_src,
  output logic [1:0] o_freq_sel,
  output logic o_ocp_high,
  output logic [1:0] o_op_mode,
  output logic o_timing_4x,
  output logic o_high_side_on,
  output logic o_low_side_on,
  output logic o_dcm,
  output logic [9:0] o_ref_mv,
  output logic o_ref_fixed,
  output logic o_power_good_out_o,
  output logic o_power_good_out_oe
);

  // ==========================================================================
  // Parameter checks
  // ==========================================================================
  localparam int STEP_CYCLES = SS_CYCLES / int'(REF_MV);  // Cycles per mV.

  if (STEP_CYCLES < 1 || PG_CYCLES < 1 || ON_W < 3 ||
      SS_CYCLES * TIMING_4X_MULT >= 2 ** CNT_W ||
      PG_CYCLES * TIMING_4X_MULT >= 2 ** CNT_W) begin : g_bad_param
    $error("buck_mode_softstart_control parameters out of range");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_STRAP, ST_SOFT, ST_RUN} seq_e;
  typedef enum logic [1:0] {SW_IDLE, SW_ON, SW_OFF} sw_e;

  seq_e seq_r;               // Start-up sequence state.
  seq_e seq_nxt;
  logic [CNT_W-1:0] settle_r;  // Strap settle time counter.
  logic latch;               // Last strap cycle: sample both straps.
  logic [1:0] freq_r;
  logic ocp_high_r;
  logic [1:0] mode_r;
  logic t4x_r;
  logic src_r;               // Both strap current sources on.
  logic [CNT_W-1:0] step_r;  // Cycles within one ramp step.
  logic [CNT_W-1:0] step_len;
  logic [9:0] ref_r;         // Soft-start reference in mV.
  logic fixed_r;             // Reference has reached its fixed value.
  logic [CNT_W-1:0] pg_cnt_r;
  logic [CNT_W-1:0] pg_len;
  logic pg_oe_r;             // High pulls the power-good pin low.
  logic pg_o_r;
  sw_e sw_r;
  logic hs_r;
  logic ls_r;
  logic dcm_r;
  logic dcm_nxt;
  logic [ON_W:0] on_cnt_r;   // On-time elapsed in this pulse.
  logic [ON_W:0] on_len_r;   // On-time length fixed at pulse start.
  logic [ON_W:0] on_len_nxt;
  logic forced;
  logic run_sw;
  logic sync_mode;
  logic trig;
  logic start;
  logic zc_seen_r;           // Zero-cross seen in this off-time.
  logic zc_hit;
  logic cyc_valid_r;         // A full switching cycle has passed.
  logic zc_reached;
  logic nzc_reached;
  logic [ON_W:0] hs_len_r;   // Helper for the on-time check.

  // ==========================================================================
  // Start-up sequencer
  // ==========================================================================
  assign latch = (seq_r == ST_STRAP) && (settle_r == CNT_W'(SETTLE_CYCLES - 1));

  // Restart returns to strap sensing so a new start-up reads the pins again.
  always_comb begin
    seq_nxt = seq_r;
    if (!i_enable) begin
      seq_nxt = ST_IDLE;
    end else begin
      case (seq_r)
        ST_IDLE: begin
          seq_nxt = ST_STRAP;
        end
        ST_STRAP: begin
          if (latch) begin
            seq_nxt = ST_SOFT;
          end
        end
        ST_SOFT: begin
          if (i_restart) begin
            seq_nxt = ST_STRAP;
          end else if (ref_r == REF_MV) begin
            seq_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          if (i_restart) begin
            seq_nxt = ST_STRAP;
          end
        end
        default: begin
          seq_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // State register and strap source enables.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      seq_r <= ST_IDLE;
      src_r <= 1'b0;
    end else begin
      seq_r <= seq_nxt;
      src_r <= (seq_nxt == ST_STRAP);  // see RULE1 see RULE3
    end
  end

  // Settle counter runs only while the sources are on.
  always_ff @(posedge i_clock) begin
    if (i_rst || seq_r != ST_STRAP) begin
      settle_r <= '0;
    end else begin
      settle_r <= settle_r + 1'b1;
    end
  end

  // ==========================================================================
  // Strap decode
  // ==========================================================================
  // Sampled only at the end of the settle time; held through operation so
  // the mode and timing cannot change under load.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      freq_r <= FSW_RST;
      ocp_high_r <= OCP_HIGH_RST;
    end else if (latch) begin  // see RULE17
      case (i_freq_ocp_strap_lvl)  // see RULE2
        LVL_GND: begin
          freq_r <= FSW_1100K;
          ocp_high_r <= 1'b1;
        end
        LVL_R24K3: begin
          freq_r <= FSW_750K;
          ocp_high_r <= 1'b0;
        end
        LVL_R57K6: begin
          freq_r <= FSW_750K;
          ocp_high_r <= 1'b1;
        end
        LVL_R105K: begin
          freq_r <= FSW_2000K;
          ocp_high_r <= 1'b0;
        end
        LVL_R174K: begin
          freq_r <= FSW_2000K;
          ocp_high_r <= 1'b1;
        end
        default: begin
          freq_r <= FSW_1100K;
          ocp_high_r <= 1'b0;
        end
      endcase
    end
  end

  // Mode strap: operating mode and soft-start/power-good scaling.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mode_r <= MODE_RST;
      t4x_r <= TIMING_4X_RST;
    end else if (latch) begin  // see RULE17
      case (i_mode_strap_pin_lvl)  // see RULE4
        LVL_GND: begin
          mode_r <= MODE_FORCED;
          t4x_r <= 1'b1;
        end
        LVL_R24K3: begin
          mode_r <= MODE_HIGH_EFF;
          t4x_r <= 1'b1;
        end
        LVL_R57K6: begin
          mode_r <= MODE_HIGH_EFF;
          t4x_r <= 1'b0;
        end
        LVL_R105K: begin
          mode_r <= MODE_DIODE;
          t4x_r <= 1'b0;
        end
        LVL_R174K: begin
          mode_r <= MODE_DIODE;
          t4x_r <= 1'b1;
        end
        default: begin
          mode_r <= MODE_FORCED;
          t4x_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Soft-start reference ramp
  // ==========================================================================
  // One mV per step; the integer step length makes the ramp a little short
  // of nominal rather than long.
  assign step_len = t4x_r ? CNT_W'(STEP_CYCLES * TIMING_4X_MULT)  // see RULE12
                          : CNT_W'(STEP_CYCLES);  // see RULE11

  always_ff @(posedge i_clock) begin
    if (i_rst || seq_r == ST_IDLE || seq_r == ST_STRAP) begin
      step_r <= '0;
      ref_r <= '0;
      fixed_r <= 1'b0;
    end else if (ref_r != REF_MV) begin
      if (step_r == step_len - 1'b1) begin
        step_r <= '0;
        ref_r <= ref_r + 1'b1;
        fixed_r <= (ref_r + 1'b1 == REF_MV);  // see RULE13
      end else begin
        step_r <= step_r + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Power good
  // ==========================================================================
  assign pg_len = t4x_r ? CNT_W'(PG_CYCLES * TIMING_4X_MULT)  // see RULE12
                        : CNT_W'(PG_CYCLES);  // see RULE11

  // Delay restarts whenever feedback leaves the window.
  always_ff @(posedge i_clock) begin
    if (i_rst || seq_r != ST_RUN || !i_fb_in_window) begin
      pg_cnt_r <= '0;
    end else if (pg_cnt_r != pg_len) begin
      pg_cnt_r <= pg_cnt_r + 1'b1;
    end
  end

  // Open drain: only ever pulls low, released when good.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pg_oe_r <= 1'b1;
      pg_o_r <= 1'b0;
    end else begin
      pg_oe_r <= !(seq_r == ST_RUN && i_fb_in_window &&
                   pg_cnt_r == pg_len);  // see RULE16 see RULE11
      pg_o_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Switching pulse engine
  // ==========================================================================
  assign forced = (mode_r == MODE_FORCED);
  assign run_sw = (seq_r == ST_SOFT) || (seq_r == ST_RUN);
  // Clock-locked pulses in forced mode and in diode emulation while
  // continuous; the modulator paces high efficiency and all DCM operation.
  assign sync_mode = forced || (mode_r == MODE_DIODE && !dcm_r);  // see RULE5
  assign trig = sync_mode ? i_clock_tick : i_mod_trigger;  // see RULE8 see RULE14
  assign start = run_sw && trig && (sw_r != SW_ON);
  assign on_len_nxt = dcm_r ? ({1'b0, i_on_time} + {1'b0, i_on_time >> DCM_EXT_SHIFT})
                            : {1'b0, i_on_time};  // see RULE10

  // Switch states; the two switches are never on together.
  always_ff @(posedge i_clock) begin
    if (i_rst || !run_sw) begin
      sw_r <= SW_IDLE;
      hs_r <= 1'b0;
      ls_r <= 1'b0;
      on_cnt_r <= '0;
      on_len_r <= '0;
    end else begin
      case (sw_r)
        SW_ON: begin
          if (on_cnt_r >= on_len_r) begin
            sw_r <= SW_OFF;
            hs_r <= 1'b0;
            ls_r <= 1'b1;  // see RULE5
          end else begin
            on_cnt_r <= on_cnt_r + 1'b1;
          end
        end
        SW_IDLE, SW_OFF: begin
          if (start) begin
            sw_r <= SW_ON;
            hs_r <= 1'b1;  // see RULE5
            ls_r <= 1'b0;
            on_cnt_r <= {{ON_W{1'b0}}, 1'b1};
            on_len_r <= on_len_nxt;
          end else if (sw_r == SW_OFF && dcm_r && i_zero_cross) begin
            sw_r <= SW_IDLE;
            ls_r <= 1'b0;  // see RULE6 see RULE8
          end
        end
        default: begin
          sw_r <= SW_IDLE;
          hs_r <= 1'b0;
          ls_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Zero-cross bookkeeping and conduction state
  // ==========================================================================
  // A crossing on the very edge of a new pulse still counts for the old one.
  assign zc_hit = zc_seen_r || i_zero_cross;

  always_ff @(posedge i_clock) begin
    if (i_rst || !run_sw) begin
      zc_seen_r <= 1'b0;
      cyc_valid_r <= 1'b0;
    end else if (start) begin
      zc_seen_r <= 1'b0;
      cyc_valid_r <= 1'b1;
    end else if (i_zero_cross && sw_r != SW_ON) begin
      zc_seen_r <= 1'b1;
    end
  end

  consec_count #(
    .TARGET(ZC_ENTER_COUNT)
  ) u_zc_count (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clear(dcm_nxt != dcm_r),  // see RULE18
    .i_step(start && cyc_valid_r),
    .i_hit(zc_hit),
    .o_reached(zc_reached)
  );

  consec_count #(
    .TARGET(NZC_EXIT_COUNT)
  ) u_nzc_count (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clear(dcm_nxt != dcm_r),  // see RULE18
    .i_step(start && cyc_valid_r),
    .i_hit(!zc_hit),
    .o_reached(nzc_reached)
  );

  // Forced mode never enters DCM; the skip modes move by the counters.
  always_comb begin
    dcm_nxt = dcm_r;
    if (!run_sw || forced) begin
      dcm_nxt = 1'b0;  // see RULE15
    end else if (!dcm_r && zc_reached) begin
      dcm_nxt = 1'b1;  // see RULE9
    end else if (dcm_r && nzc_reached) begin
      dcm_nxt = 1'b0;  // see RULE7
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      dcm_r <= 1'b0;
    end else begin
      dcm_r <= dcm_nxt;
    end
  end

  // Helper count of high-side cycles, read only by the checks below.
  always_ff @(posedge i_clock) begin
    if (i_rst || !hs_r) begin
      hs_len_r <= '0;
    end else begin
      hs_len_r <= hs_len_r + 1'b1;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_freq_ocp_strap_src = src_r;
  assign o_mode_strap_pin_src = src_r;
  assign o_freq_sel = freq_r;
  assign o_ocp_high = ocp_high_r;
  assign o_op_mode = mode_r;
  assign o_timing_4x = t4x_r;
  assign o_high_side_on = hs_r;
  assign o_low_side_on = ls_r;
  assign o_dcm = dcm_r;
  assign o_ref_mv = ref_r;
  assign o_ref_fixed = fixed_r;
  assign o_power_good_out_o = pg_o_r;
  assign o_power_good_out_oe = pg_oe_r;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  AST_SRC_IN_STRAP: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE1
    src_r == (seq_r == ST_STRAP)) else $error("strap source outside sensing");
  AST_STRAP_HOLD: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE17
    (seq_r != ST_STRAP) |=> $stable(mode_r) && $stable(t4x_r) && $stable(freq_r))
    else $error("strap setting changed outside sensing");
  AST_NO_OVERLAP: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE5
    !(hs_r && ls_r)) else $error("both switches on");
  AST_SYNC_TICK: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE5
    ($rose(hs_r) && $past(sync_mode)) |-> $past(i_clock_tick))
    else $error("clock-locked pulse without a tick");
  AST_ZC_LS_OFF: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE6
    (run_sw && dcm_r && sw_r == SW_OFF && i_zero_cross) |=> !ls_r)
    else $error("low side left on after zero-cross");
  AST_ENTER_DCM: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE9
    $rose(dcm_r) |-> $past(zc_reached) && !$past(forced))
    else $error("entered DCM without seven zero-crosses");
  AST_FORCED_CCM: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE15
    (forced && $past(forced)) |-> !dcm_r) else $error("forced mode in DCM");
  AST_ON_LEN: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE10
    ($fell(hs_r) && $past(run_sw) && run_sw) |-> hs_len_r == $past(on_len_r))
    else $error("on-pulse length wrong");
  AST_RUN_REF: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE13
    (seq_r == ST_RUN) |-> (ref_r == REF_MV) && fixed_r)
    else $error("reference not fixed while running");
  AST_PG_WINDOW: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE16
    !pg_oe_r |-> $past(i_fb_in_window) && $past(pg_cnt_r) == $past(pg_len))
    else $error("power good released outside window or early");

endmodule

`default_nettype wire

/* File: dv/buck_far_side.sv */
// Far side model: strap resistors, oscillator, modulator, zero-cross comparator.
// Assumes the control block samples these outputs on the rising clock edge.
`default_nettype none
module buck_far_side (
  input wire logic i_clock,
  input wire logic i_freq_src,
  input wire logic i_mode_src,
  input wire logic [2:0] i_freq_code,
  input wire logic [2:0] i_mode_code,
  input wire logic i_low_side,
  input wire logic i_light,
  output logic [2:0] o_freq_lvl = 3'h7,
  output logic [2:0] o_mode_lvl = 3'h7,
  output logic o_tick = 1'b0,
  output logic o_trig = 1'b0,
  output logic o_zc = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] div_r = 6'h0;
  logic [1:0] ls_r = 2'h0;
  // A strap only reads true while it is sourced; otherwise the code keeps moving.
  always @(negedge i_clock) begin
    div_r <= div_r + 6'h1;
    ls_r <= {ls_r[0], i_low_side};
    o_freq_lvl <= i_freq_src ? i_freq_code : ~div_r[2:0];
    o_mode_lvl <= i_mode_src ? i_mode_code : div_r[2:0];
    o_tick <= (div_r == 6'h3F);
    o_trig <= (div_r[4:0] == 5'h1F);
    // At light load the current reaches zero just after the low side turns on.
    o_zc <= i_light && (ls_r == 2'h1);
  end
endmodule
`default_nettype wire

/* File: dv/buck_mode_softstart_control_tb.sv */
// Self-checking bench for the buck start-up and conduction control.
// Assumes the package and the far side model are compiled before it.
`default_nettype none
module buck_mode_softstart_control_tb;
  import buck_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Signals and expected strap tables
  // ==========================================================================
  localparam logic [1:0] FS[6] = '{FSW_1100K, FSW_750K, FSW_750K, FSW_2000K, FSW_2000K, FSW_1100K};
  localparam logic [1:0] MD[6] = '{MODE_FORCED, MODE_HIGH_EFF, MODE_HIGH_EFF, MODE_DIODE,
                                   MODE_DIODE, MODE_FORCED};
  localparam logic [5:0] OC = 6'h15;  // One bit per level code.
  localparam logic [5:0] X4 = 6'h13;  // One bit per level code.
  logic i_clock = 1'b0, i_rst = 1'b1, en = 1'b0, rst_p = 1'b0, win = 1'b1, light = 1'b0;
  logic [7:0] on_t = 8'h4, lfsr = 8'h7;
  logic [2:0] fcode = 3'h0, mcode = 3'h0, flvl, mlvl;
  logic tick, trig, zc, fsrc, msrc, hs, ls, dcm, rfix, pg_o, pg_oe, overcurrent_limit, t4, src_q = 1'b0;
  logic [1:0] fsel, mode;
  logic [9:0] ref_mv;
  logic [5:0] expq[$];
  int miscompares = 0, comparisons = 0, n = 0, cyc = 0;
  initial forever #10 i_clock = ~i_clock;
  buck_mode_softstart_control #(.SS_CYCLES(1200), .PG_CYCLES(50)) u_buck_mode_softstart_control (
    .i_clock(i_clock), .i_rst(i_rst), .i_enable(en), .i_restart(rst_p),
    .i_freq_ocp_strap_lvl(flvl), .i_mode_strap_pin_lvl(mlvl), .i_clock_tick(tick),
    .i_mod_trigger(trig), .i_on_time(on_t), .i_zero_cross(zc), .i_fb_in_window(win),
    .i_power_good_out_i(~pg_oe), .o_freq_ocp_strap_src(fsrc), .o_mode_strap_pin_src(msrc),
    .o_freq_sel(fsel), .o_ocp_high(overcurrent_limit), .o_op_mode(mode), .o_timing_4x(t4),
    .o_high_side_on(hs), .o_low_side_on(ls), .o_dcm(dcm), .o_ref_mv(ref_mv),
    .o_ref_fixed(rfix), .o_power_good_out_o(pg_o), .o_power_good_out_oe(pg_oe));
  buck_far_side u_buck_far_side (.i_clock(i_clock), .i_freq_src(fsrc), .i_mode_src(msrc),
    .i_freq_code(fcode), .i_mode_code(mcode), .i_low_side(ls), .i_light(light),
    .o_freq_lvl(flvl), .o_mode_lvl(mlvl), .o_tick(tick), .o_trig(trig), .o_zc(zc));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bounded wait; n ends as the number of falling edges spent waiting.
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge i_clock);
      n++;
    end
  endtask
  // Measures one whole high-side pulse, then the low side must take over.
  task automatic pulse(input logic [9:0] exp);
    wait_for(hs, 1'b0, 40);
    wait_for(hs, 1'b1, 100);
    wait_for(hs, 1'b0, 40);
    check("on_time", 10'(n), exp);
    check("low_side", 10'(ls), 10'h1);
  endtask
  task automatic results();
    check("pending", 10'(expq.size()), 10'h0);
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // The end of sourcing marks a latch; the oldest note is compared then.
  always @(negedge i_clock) begin
    src_q <= msrc;
    if (src_q && !msrc && expq.size() > 0) begin
      check("straps", 10'({fsel, overcurrent_limit, mode, t4}), 10'(expq.pop_front()));
    end
  end
  // A hang is cut short well beyond the expected run of about 7000 cycles.
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 12000) begin
      miscompares++;
      results();
    end
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (12) @(negedge i_clock);
    i_rst = 1'b0;
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    on_t = 8'h4 + {5'h0, lfsr[2:0]};
    check("reset", 10'({fsel, overcurrent_limit, mode, t4, pg_oe}),
          10'({FSW_RST, OCP_HIGH_RST, MODE_RST, TIMING_4X_RST, 1'b1}));
    en = 1'b1;
    // Every level code on both straps; each restart must latch afresh.
    for (int i = 0; i < 6; i++) begin
      fcode = 3'(i);
      mcode = 3'((i + 3) % 6);
      expq.push_back({FS[i], OC[i], MD[mcode], X4[mcode]});
      if (i > 0) begin
        rst_p = 1'b1;
        @(negedge i_clock);
        rst_p = 1'b0;
      end
      repeat (2) @(negedge i_clock);
      check("src", 10'({fsrc, msrc}), 10'h3);
      wait_for(msrc, 1'b0, 600);
      @(negedge i_clock);
    end
    $display("test straps done");
    wait_for(rfix, 1'b1, 1400);
    check("ss_time", 10'(n > 1190 && n < 1210), 10'h1);
    check("ref", ref_mv, REF_MV);
    wait_for(pg_oe, 1'b0, 200);
    check("pg_delay", 10'(n > 48 && n < 55), 10'h1);
    win = 1'b0;
    repeat (2) @(negedge i_clock);
    check("pg_lost", 10'({pg_oe, pg_o}), 10'h2);
    win = 1'b1;
    $display("test soft start done");
    pulse(10'(on_t));
    light = 1'b1;
    wait_for(dcm, 1'b1, 600);
    // Seven marked pulses at 32 cycles each land near 215 cycles.
    check("dcm_count", 10'(dcm && n > 200 && n < 230), 10'h1);
    pulse(10'(on_t + (on_t >> 2)));
    repeat (5) @(negedge i_clock);
    check("ls_zero", 10'(ls), 10'h0);
    light = 1'b0;
    wait_for(dcm, 1'b0, 100);
    // Two unmarked pulses after one marked one take about 80 cycles.
    check("ccm", 10'(!dcm && n > 64), 10'h1);
    $display("test conduction done");
    // Restart into forced continuous: light load must never reach DCM.
    mcode = 3'h5;
    expq.push_back({FS[5], OC[5], MD[5], X4[5]});
    rst_p = 1'b1;
    @(negedge i_clock);
    rst_p = 1'b0;
    wait_for(msrc, 1'b0, 600);
    wait_for(rfix, 1'b1, 1400);
    light = 1'b1;
    pulse(10'(on_t));
    repeat (600) @(negedge i_clock);
    check("forced_ccm", 10'({dcm, ls}), 10'h1);
    $display("test forced mode done");
    results();
  end
endmodule
`default_nettype wire
